// *** rtl/uart_cmd_pkg.sv ***
package uart_cmd_pkg;

  // ---------------------------------------------------------------
  // clocking and baud generation
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned REF_HZ = 3_686_400;
  localparam int unsigned ACC_W = 24;
  localparam logic [4:0] TICKS_PER_BIT = 5'h10;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_CLOCK_SELECT = 8'h04;
  localparam logic [7:0] OFS_AUX_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_CHAN_STATE = 8'h14;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CMD_RX_EN = 0;
  localparam int unsigned CMD_RX_DIS = 1;
  localparam int unsigned CMD_TX_EN = 2;
  localparam int unsigned CMD_TX_DIS = 3;
  localparam int unsigned AUX_ALT_SET = 7;
  localparam int unsigned ISR_BREAK_CHG = 2;
  localparam int unsigned ISR_CT_READY = 3;
  localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] RST_AUX_CONTROL = 8'h00;
  localparam logic [1:0] PTR_MODE_ZERO = 2'h0;
  localparam logic [1:0] PTR_MODE_FIRST = 2'h1;

  // ---------------------------------------------------------------
  // commands in the upper nibble of the command register
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP = 4'b0000,
    CMD_PTR_FIRST = 4'b0001,
    CMD_RX_RESET = 4'b0010,
    CMD_TX_RESET = 4'b0011,
    CMD_ERR_RESET = 4'b0100,
    CMD_BRK_CHG_RESET = 4'b0101,
    CMD_BREAK_START = 4'b0110,
    CMD_BREAK_STOP = 4'b0111,
    CMD_RTS_ON = 4'b1000,
    CMD_RTS_OFF = 4'b1001,
    CMD_TIMEOUT_ON = 4'b1010,
    CMD_PTR_ZERO = 4'b1011,
    CMD_TIMEOUT_OFF = 4'b1100,
    CMD_BLOCK_ERR = 4'b1101,
    CMD_TEST_A = 4'b1110,
    CMD_TEST_B = 4'b1111
  } command_t;

  localparam logic [3:0] CSEL_TIMER = 4'b1101;
  localparam logic [3:0] CSEL_EXT16 = 4'b1110;
  localparam logic [3:0] CSEL_EXT1 = 4'b1111;

  typedef enum logic [1:0] {
    TX_OFF = 2'b00,
    TX_RUN = 2'b01,
    TX_DRAIN = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_WAIT = 2'b01,
    BRK_ON = 2'b10,
    BRK_MARK = 2'b11
  } brk_state_t;

endpackage : uart_cmd_pkg

// *** rtl/uart_baud_select.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_baud_select (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] code_i,
  input wire logic alt_set_i,
  input wire logic timer_tick_i,
  input wire logic ext_pin_i,
  output logic tick16_o,
  output logic one_x_o
);
  import uart_cmd_pkg::*;

  // ---------------------------------------------------------------
  // rate table, in half-baud units so 134.5 stays exact
  // ---------------------------------------------------------------
  function automatic logic [16:0] half_baud(input logic [3:0] c,
                                            input logic alt);
    logic [16:0] r;
    r = 17'h0;
    unique case (c)
      4'h0: r = alt ? 17'h00096 : 17'h00064;
      4'h1: r = 17'h000dc;
      4'h2: r = 17'h0010d;
      4'h3: r = alt ? 17'h0012c : 17'h00190;
      4'h4: r = 17'h00258;
      4'h5: r = 17'h004b0;
      4'h6: r = 17'h00960;
      4'h7: r = alt ? 17'h00fa0 : 17'h00834;
      4'h8: r = 17'h012c0;
      4'h9: r = 17'h02580;
      4'ha: r = alt ? 17'h00e10 : 17'h03840;
      4'hb: r = 17'h04b00;
      4'hc: r = alt ? 17'h09600 : 17'h12c00;
      default: r = 17'h0;
    endcase
    return r;
  endfunction : half_baud

  // 16x frequency = half_baud * 8, scaled to the accumulator
  logic [63:0] inc_wide;
  logic [ACC_W-1:0] inc;
  logic [ACC_W:0] sum;
  logic [ACC_W-1:0] acc;
  logic pin_prev;
  logic pin_rise;
  logic next_tick;

  assign inc_wide = ({47'h0, half_baud(code_i, alt_set_i)} << 27)
                    / 64'(CLK_HZ);
  assign inc = inc_wide[ACC_W-1:0];
  assign sum = {1'b0, acc} + {1'b0, inc};
  assign pin_rise = ext_pin_i & ~pin_prev;
  assign next_tick = (code_i == CSEL_TIMER) ? timer_tick_i :
                     (code_i >= CSEL_EXT16) ? pin_rise : sum[ACC_W];

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc <= '0;
      pin_prev <= 1'b0;
      tick16_o <= 1'b0;
      one_x_o <= 1'b0;
    end else begin
      acc <= sum[ACC_W-1:0];
      pin_prev <= ext_pin_i;
      tick16_o <= next_tick;
      one_x_o <= (code_i == CSEL_EXT1);
    end
  end

endmodule : uart_baud_select
`default_nettype wire

// *** rtl/uart_channel_command.sv ***
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - pointer commands select first or zero mode
// - receiver reset: disabled, queue pointer restarted
// - transmitter reset returns hardware reset state
// - error reset clears four status error bits in block mode, only overrun in character mode
// - break-change reset clears interrupt status bit
// - start break forces line low after drain
// - break starts only with transmitter enabled
// - stop break then one bit marking
// - commands assert or negate request to send
// - timeout mode stops counter, restarts on loads
// - shared counter restarts on either receiver
// - timeout off returns counter control, no stop
// - block error mode until receiver reset
// - receiver clock select, code 1111 external 1x
// - transmitter codes 1110/1111 use pin three
// - baud generator gives sixteen times rate
// - disable clears flags, queue still drains
// - refuse queue loads while disabled or pending
// - enable starts transmitter, sets both flags
// - receiver disable immediate, queue kept readable
// - after stop-bit sample, hunt next start
// - receiver enable forces start search state, except in wake-up mode
// - auxiliary bit picks alternate rate set
module uart_channel_command (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic rx_char_load_i,
  input wire logic [3:0] rx_load_err_i,
  input wire logic [3:0] rx_top_err_i,
  input wire logic rx_queue_ready_i,
  input wire logic rx_queue_full_i,
  input wire logic rx_stop_sampled_i,
  input wire logic wake_up_mode_i,
  input wire logic peer_char_load_i,
  input wire logic peer_timeout_mode_i,
  input wire logic tx_write_i,
  input wire logic tx_queue_full_i,
  input wire logic tx_queue_empty_i,
  input wire logic tx_shift_idle_i,
  input wire logic break_change_i,
  input wire logic counter_ready_i,
  input wire logic timer_tick_i,
  input wire logic aux_pin_two_i,
  input wire logic aux_pin_three_i,
  output logic rx_enable_o,
  output logic rx_reset_o,
  output logic rx_hunt_o,
  output logic tx_enable_o,
  output logic tx_reset_o,
  output logic tx_load_o,
  output logic tx_hold_o,
  output logic serial_break_o,
  output logic request_to_send_n_o,
  output logic [1:0] mode_pointer_o,
  output logic timeout_mode_o,
  output logic ct_stop_o,
  output logic ct_restart_o,
  output logic block_error_mode_o,
  output logic transmitter_ready_flag_o,
  output logic transmitter_empty_flag_o,
  output logic rx_tick16_o,
  output logic rx_one_x_o,
  output logic tx_tick16_o,
  output logic tx_one_x_o
);
  import uart_cmd_pkg::*;

  // ---------------------------------------------------------------
  // bus slave: zero wait states, read data sampled in address phase
  // ---------------------------------------------------------------
  logic addr_take;
  logic wr_pend;
  logic [7:0] wr_ofs;
  logic [31:0] rd_mux;
  logic [7:0] channel_clock_select;
  logic [7:0] auxiliary_control;
  logic [3:0] err_status;
  logic break_change;
  logic counter_ready;

  assign addr_take = hsel_i & hready_i & htrans_i[1];

  always_comb begin
    rd_mux = 32'h0;
    unique case (haddr_i[7:0])
      OFS_AUX_CONTROL: rd_mux = {24'h0, auxiliary_control};
      OFS_STATUS: rd_mux = {24'h0, err_status,
                            transmitter_empty_flag_o,
                            transmitter_ready_flag_o,
                            rx_queue_full_i, rx_queue_ready_i};
      OFS_INT_STATUS: rd_mux = {28'h0, counter_ready, break_change,
                                2'b00};
      OFS_CHAN_STATE: rd_mux = {22'h0, mode_pointer_o, serial_break_o,
                                request_to_send_n_o, block_error_mode_o,
                                timeout_mode_o, tx_enable_o,
                                rx_enable_o};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h0;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend <= addr_take & hwrite_i;
      if (addr_take) begin
        wr_ofs <= haddr_i[7:0];
      end
      if (addr_take & ~hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic wr_cmd;
  logic [3:0] cmd_code;
  logic do_cmd;
  logic do_ptr_first;
  logic do_ptr_zero;
  logic do_rx_reset;
  logic do_tx_reset;
  logic do_err_reset;
  logic do_brk_chg_reset;
  logic do_break_start;
  logic do_break_stop;
  logic do_timeout_on;
  logic do_timeout_off;
  logic do_tx_en;
  logic do_tx_dis;
  logic do_rx_en;
  logic do_rx_dis;

  assign wr_cmd = wr_pend & (wr_ofs == OFS_COMMAND);
  assign cmd_code = hwdata_i[7:4];
  // test codes fall through every compare below
  assign do_cmd = wr_cmd;
  assign do_ptr_first = do_cmd & (cmd_code == CMD_PTR_FIRST);
  assign do_ptr_zero = do_cmd & (cmd_code == CMD_PTR_ZERO);
  assign do_rx_reset = do_cmd & (cmd_code == CMD_RX_RESET);
  assign do_tx_reset = do_cmd & (cmd_code == CMD_TX_RESET);
  assign do_err_reset = do_cmd & (cmd_code == CMD_ERR_RESET);
  assign do_brk_chg_reset = do_cmd & (cmd_code == CMD_BRK_CHG_RESET);
  assign do_break_start = do_cmd & (cmd_code == CMD_BREAK_START);
  assign do_break_stop = do_cmd & (cmd_code == CMD_BREAK_STOP);
  assign do_timeout_on = do_cmd & (cmd_code == CMD_TIMEOUT_ON);
  assign do_timeout_off = do_cmd & (cmd_code == CMD_TIMEOUT_OFF);
  assign do_tx_en = wr_cmd & hwdata_i[CMD_TX_EN];
  assign do_tx_dis = wr_cmd & hwdata_i[CMD_TX_DIS];
  assign do_rx_en = wr_cmd & hwdata_i[CMD_RX_EN];
  assign do_rx_dis = wr_cmd & hwdata_i[CMD_RX_DIS];

  // ---------------------------------------------------------------
  // writable configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      channel_clock_select <= RST_CLOCK_SELECT;
      auxiliary_control <= RST_AUX_CONTROL;
    end else begin
      if (wr_pend & (wr_ofs == OFS_CLOCK_SELECT)) begin
        channel_clock_select <= hwdata_i[7:0];
      end
      if (wr_pend & (wr_ofs == OFS_AUX_CONTROL)) begin
        auxiliary_control <= hwdata_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // mode pointer, request to send, counter/timer control
  // ---------------------------------------------------------------
  logic peer_load;
  assign peer_load = peer_char_load_i & peer_timeout_mode_i;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_pointer_o <= PTR_MODE_FIRST;
      request_to_send_n_o <= 1'b1;
      timeout_mode_o <= 1'b0;
      ct_stop_o <= 1'b0;
      ct_restart_o <= 1'b0;
    end else begin
      if (do_ptr_first) begin
        mode_pointer_o <= PTR_MODE_FIRST;
      end else if (do_ptr_zero) begin
        mode_pointer_o <= PTR_MODE_ZERO;
      end
      if (do_cmd & (cmd_code == CMD_RTS_ON)) begin
        request_to_send_n_o <= 1'b0;
      end else if (do_cmd & (cmd_code == CMD_RTS_OFF)) begin
        request_to_send_n_o <= 1'b1;
      end
      // turning off leaves the counter running; software stops it
      if (do_timeout_on) begin
        timeout_mode_o <= 1'b1;
      end else if (do_timeout_off) begin
        timeout_mode_o <= 1'b0;
      end
      ct_stop_o <= do_timeout_on;
      ct_restart_o <= timeout_mode_o &
                      (rx_char_load_i | peer_load);
    end
  end

  // ---------------------------------------------------------------
  // error and interrupt status; a set in the clear cycle survives
  // ---------------------------------------------------------------
  logic [3:0] err_set;
  logic [3:0] next_err;

  // character mode follows the queue head, overrun stays sticky
  assign err_set = rx_char_load_i ? rx_load_err_i : 4'h0;
  assign next_err = block_error_mode_o ?
                    ((do_err_reset ? 4'h0 : err_status) | err_set) :
                    {rx_top_err_i[3:1],
                     (err_status[0] & ~do_err_reset) | err_set[0]};

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_status <= 4'h0;
      break_change <= 1'b0;
      counter_ready <= 1'b0;
    end else begin
      err_status <= next_err;
      break_change <= break_change_i |
                      (break_change & ~do_brk_chg_reset);
      counter_ready <= (counter_ready_i & ~timeout_mode_o) |
                       (counter_ready & ~do_timeout_on);
    end
  end

  // ---------------------------------------------------------------
  // receiver control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_enable_o <= 1'b0;
      rx_reset_o <= 1'b0;
      rx_hunt_o <= 1'b0;
      block_error_mode_o <= 1'b0;
    end else begin
      rx_reset_o <= do_rx_reset;
      // a disable drops the partial character, queue is untouched
      if (do_rx_reset | do_rx_dis) begin
        rx_enable_o <= 1'b0;
      end else if (do_rx_en) begin
        rx_enable_o <= 1'b1;
      end
      rx_hunt_o <= (do_rx_en & ~do_rx_dis & ~do_rx_reset &
                    ~wake_up_mode_i) |
                   (rx_enable_o & rx_stop_sampled_i);
      if (do_rx_reset) begin
        block_error_mode_o <= 1'b0;
      end else if (do_cmd & (cmd_code == CMD_BLOCK_ERR)) begin
        block_error_mode_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmitter control
  // ---------------------------------------------------------------
  tx_state_t tx_state;
  tx_state_t next_tx_state;
  logic tx_drained;
  logic next_ready;
  logic next_empty;

  assign tx_drained = tx_queue_empty_i & tx_shift_idle_i;

  always_comb begin
    next_tx_state = tx_state;
    next_ready = transmitter_ready_flag_o;
    next_empty = transmitter_empty_flag_o;
    if (do_tx_reset) begin
      next_tx_state = TX_OFF;
      next_ready = 1'b0;
      next_empty = 1'b0;
    end else if (do_tx_dis & (tx_state != TX_OFF)) begin
      next_tx_state = tx_drained ? TX_OFF : TX_DRAIN;
      next_ready = 1'b0;
      next_empty = 1'b0;
    end else if (do_tx_en) begin
      next_tx_state = TX_RUN;
      next_ready = 1'b1;
      next_empty = 1'b1;
    end else begin
      unique case (tx_state)
        TX_OFF: begin
          next_ready = 1'b0;
          next_empty = 1'b0;
        end
        TX_RUN: begin
          next_ready = ~tx_queue_full_i;
          next_empty = tx_drained;
        end
        TX_DRAIN: begin
          next_ready = 1'b0;
          next_empty = 1'b0;
          if (tx_drained) begin
            next_tx_state = TX_OFF;
          end
        end
        default: next_tx_state = TX_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_state <= TX_OFF;
      transmitter_ready_flag_o <= 1'b0;
      transmitter_empty_flag_o <= 1'b0;
      tx_enable_o <= 1'b0;
      tx_reset_o <= 1'b0;
      tx_load_o <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      transmitter_ready_flag_o <= next_ready;
      transmitter_empty_flag_o <= next_empty;
      tx_enable_o <= (next_tx_state != TX_OFF);
      tx_reset_o <= do_tx_reset;
      tx_load_o <= tx_write_i & (tx_state == TX_RUN) &
                   ~tx_queue_full_i;
    end
  end

  // ---------------------------------------------------------------
  // break generation
  // ---------------------------------------------------------------
  brk_state_t brk_state;
  brk_state_t next_brk_state;
  logic [4:0] mark_count;
  logic mark_done;

  // 1x clock needs a single tick for a full bit
  assign mark_done = tx_tick16_o &
                     (tx_one_x_o | (mark_count == TICKS_PER_BIT - 5'h1));

  always_comb begin
    next_brk_state = brk_state;
    if (do_tx_reset) begin
      next_brk_state = BRK_IDLE;
    end else begin
      unique case (brk_state)
        BRK_IDLE: begin
          if (do_break_start & (tx_state == TX_RUN)) begin
            next_brk_state = BRK_WAIT;
          end
        end
        BRK_WAIT: begin
          if (do_break_stop) begin
            next_brk_state = BRK_IDLE;
          end else if (tx_drained) begin
            next_brk_state = BRK_ON;
          end
        end
        BRK_ON: begin
          if (do_break_stop) begin
            next_brk_state = BRK_MARK;
          end
        end
        BRK_MARK: begin
          if (mark_done) begin
            next_brk_state = BRK_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      brk_state <= BRK_IDLE;
      mark_count <= 5'h0;
      serial_break_o <= 1'b0;
      tx_hold_o <= 1'b0;
    end else begin
      brk_state <= next_brk_state;
      if (brk_state != BRK_MARK) begin
        mark_count <= 5'h0;
      end else if (tx_tick16_o) begin
        mark_count <= mark_count + 5'h1;
      end
      serial_break_o <= (next_brk_state == BRK_ON);
      tx_hold_o <= (next_brk_state == BRK_ON) |
                   (next_brk_state == BRK_MARK);
    end
  end

  // ---------------------------------------------------------------
  // baud clock selection, receiver on pin two, transmitter on three
  // ---------------------------------------------------------------
  uart_baud_select rx_baud (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .code_i(channel_clock_select[7:4]),
    .alt_set_i(auxiliary_control[AUX_ALT_SET]),
    .timer_tick_i(timer_tick_i),
    .ext_pin_i(aux_pin_two_i),
    .tick16_o(rx_tick16_o),
    .one_x_o(rx_one_x_o)
  );

  uart_baud_select tx_baud (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .code_i(channel_clock_select[3:0]),
    .alt_set_i(auxiliary_control[AUX_ALT_SET]),
    .timer_tick_i(timer_tick_i),
    .ext_pin_i(aux_pin_three_i),
    .tick16_o(tx_tick16_o),
    .one_x_o(tx_one_x_o)
  );

endmodule : uart_channel_command
`default_nettype wire

// *** testbench/uart_channel_command_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_channel_command_asserts (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic rx_reset_o,
  input wire logic rx_enable_o,
  input wire logic block_error_mode_o,
  input wire logic rx_char_load_i,
  input wire logic peer_char_load_i,
  input wire logic peer_timeout_mode_i,
  input wire logic timeout_mode_o,
  input wire logic ct_restart_o,
  input wire logic tx_write_i,
  input wire logic tx_queue_full_i,
  input wire logic tx_queue_empty_i,
  input wire logic tx_shift_idle_i,
  input wire logic tx_load_o,
  input wire logic tx_enable_o,
  input wire logic tx_reset_o,
  input wire logic tx_hold_o,
  input wire logic serial_break_o,
  input wire logic transmitter_ready_flag_o,
  input wire logic transmitter_empty_flag_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_rxr; rx_reset_o |-> !rx_enable_o; endproperty
  a_rxr: assert property (p_rxr) else $error("rx on at reset");
  property p_blk; $fell(block_error_mode_o) |-> rx_reset_o; endproperty
  a_blk: assert property (p_blk) else $error("block mode lost");
  property p_tmo; rx_char_load_i && timeout_mode_o |=> ct_restart_o;
  endproperty
  a_tmo: assert property (p_tmo) else $error("no restart");
  property p_peer;
    peer_char_load_i && peer_timeout_mode_i && timeout_mode_o
      |=> ct_restart_o;
  endproperty
  a_peer: assert property (p_peer) else $error("no peer restart");
  property p_ld;
    tx_load_o |-> $past(tx_write_i && transmitter_ready_flag_o &&
      !tx_queue_full_i);
  endproperty
  a_ld: assert property (p_ld) else $error("load refused late");
  property p_brk;
    $rose(serial_break_o) |->
      $past(tx_enable_o && tx_queue_empty_i && tx_shift_idle_i);
  endproperty
  a_brk: assert property (p_brk) else $error("break early");
  property p_mark; $fell(serial_break_o) && !tx_reset_o |-> tx_hold_o;
  endproperty
  a_mark: assert property (p_mark) else $error("no mark bit");
  property p_en;
    $rose(transmitter_ready_flag_o) && !$past(tx_enable_o) |->
      transmitter_empty_flag_o && tx_enable_o;
  endproperty
  a_en: assert property (p_en) else $error("enable flags");
endmodule : uart_channel_command_asserts
bind uart_channel_command uart_channel_command_asserts asserts_i (
  .clk_sys_i, .sys_rst_i, .rx_reset_o, .rx_enable_o, .block_error_mode_o,
  .rx_char_load_i, .peer_char_load_i, .peer_timeout_mode_i,
  .timeout_mode_o, .ct_restart_o, .tx_write_i, .tx_queue_full_i,
  .tx_queue_empty_i, .tx_shift_idle_i, .tx_load_o, .tx_enable_o,
  .tx_reset_o, .tx_hold_o, .serial_break_o, .transmitter_ready_flag_o,
  .transmitter_empty_flag_o);
`default_nettype wire

// *** testbench/uart_tx_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_tx_partner (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic tx_load_i,
  output logic full_o,
  output logic empty_o,
  output logic idle_o
);
  logic [3:0] depth;
  logic [5:0] shift;
  wire logic take = (shift == 6'h0) && (depth != 4'h0);
  // 64 clocks a char: slow, so a pending disable stays visible
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      depth <= 4'h0;
      shift <= 6'h0;
    end else begin
      depth <= depth + {3'h0, tx_load_i} - {3'h0, take};
      shift <= take ? 6'h3f : shift - {5'h0, shift != 6'h0};
    end
  end
  assign full_o = (depth == 4'h8);
  assign empty_o = (depth == 4'h0);
  assign idle_o = (shift == 6'h0);
endmodule : uart_tx_partner
`default_nettype wire

// *** testbench/uart_channel_command_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_channel_command_tb;
  import uart_cmd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] q;
  logic [3:0] rx_load_err_i = 4'h0;
  logic [5:0] ev = 6'h0;
  logic [7:0] cnt = 8'h0;
  logic [15:0] tbl [12] = '{16'h8040, 16'h9050, 16'hb010, 16'h1050,
    16'ha054, 16'hc050, 16'hd058, 16'he058, 16'hf058, 16'h0058,
    16'h0159, 16'h2050};
  int err_count = 0;
  int check_count = 0;
  int loads = 0;
  wire logic [31:0] hrdata_o;
  wire logic hreadyout_o, tx_load_o, tx_hold_o, rx_one_x_o, tx_one_x_o;
  wire logic tx_queue_full_i, tx_queue_empty_i, tx_shift_idle_i;
  wire logic timer_tick_i = (cnt[2:0] == 3'h0);
  uart_channel_command uart_channel_command_i (
    .clk_sys_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o(), .rx_char_load_i(ev[0]), .rx_load_err_i,
    .rx_top_err_i(rx_load_err_i), .rx_queue_ready_i(1'b1),
    .rx_queue_full_i(1'b0), .rx_stop_sampled_i(ev[5]),
    .wake_up_mode_i(1'b0), .peer_char_load_i(ev[1]),
    .peer_timeout_mode_i(1'b1), .tx_write_i(ev[2]), .tx_queue_full_i,
    .tx_queue_empty_i, .tx_shift_idle_i, .break_change_i(ev[3]),
    .counter_ready_i(ev[4]), .timer_tick_i, .aux_pin_two_i(cnt[3]),
    .aux_pin_three_i(cnt[4]), .rx_enable_o(), .rx_reset_o(),
    .rx_hunt_o(), .tx_enable_o(), .tx_reset_o(), .tx_load_o, .tx_hold_o,
    .serial_break_o(), .request_to_send_n_o(), .mode_pointer_o(),
    .timeout_mode_o(), .ct_stop_o(), .ct_restart_o(),
    .block_error_mode_o(), .transmitter_ready_flag_o(),
    .transmitter_empty_flag_o(), .rx_tick16_o(), .rx_one_x_o,
    .tx_tick16_o(), .tx_one_x_o);
  uart_tx_partner uart_tx_partner_i (.clk_sys_i, .sys_rst_i,
    .tx_load_i(tx_load_o), .full_o(tx_queue_full_i),
    .empty_o(tx_queue_empty_i), .idle_o(tx_shift_idle_i));
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cnt <= cnt + 8'h1;
    if (tx_load_o === 1'b1) loads++;
  end
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    q = hrdata_o;
  endtask : bus
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd
  task automatic cmd(input logic [7:0] v);
    bus(1'b1, 8'h00, {24'h0, v});
    repeat (48) @(posedge clk_sys_i);
  endtask : cmd
  task automatic pulse(input logic [5:0] m);
    ev <= m;
    @(posedge clk_sys_i);
    ev <= 6'h0;
    @(posedge clk_sys_i);
  endtask : pulse
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd(8'h14, 32'h50);
    for (int i = 0; i < 12; i++) begin
      cmd(tbl[i][15:8]);
      rd(8'h14, {24'h0, tbl[i][7:0]});
    end
    $display("test commands done");
    bus(1'b1, 8'h08, 32'h80);
    rd(8'h08, 32'h80);
    bus(1'b1, 8'h04, 32'hff);
    repeat (2) @(posedge clk_sys_i);
    chk("one_x", 32'h3, {30'h0, rx_one_x_o, tx_one_x_o});
    bus(1'b1, 8'h04, 32'hee);
    repeat (2) @(posedge clk_sys_i);
    chk("one_x", 32'h0, {30'h0, rx_one_x_o, tx_one_x_o});
    bus(1'b1, 8'h04, 32'hdd);
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h0);
    $display("test clock select done");
    cmd(8'h04);
    rd(8'h0c, 32'h0d);
    pulse(6'h04);
    pulse(6'h04);
    cmd(8'h08);
    rd(8'h0c, 32'h01);
    rd(8'h14, 32'h52);
    pulse(6'h04);
    repeat (200) @(posedge clk_sys_i);
    rd(8'h14, 32'h50);
    chk("loads", 32'h2, loads);
    $display("test transmitter done");
    cmd(8'h60);
    rd(8'h14, 32'h50);
    cmd(8'h04);
    cmd(8'h60);
    rd(8'h14, 32'h72);
    cmd(8'h70);
    chk("hold", 32'h1, {31'h0, tx_hold_o});
    rd(8'h14, 32'h52);
    repeat (150) @(posedge clk_sys_i);
    chk("hold", 32'h0, {31'h0, tx_hold_o});
    cmd(8'h30);
    rd(8'h14, 32'h50);
    $display("test break done");
    pulse(6'h18);
    rd(8'h10, 32'h0c);
    cmd(8'h50);
    rd(8'h10, 32'h08);
    cmd(8'ha0);
    rd(8'h10, 32'h00);
    cmd(8'hd0);
    rx_load_err_i <= 4'hf;
    pulse(6'h03);
    rx_load_err_i <= 4'h0;
    rd(8'h0c, 32'hf1);
    cmd(8'h40);
    rd(8'h0c, 32'h01);
    cmd(8'hc0);
    rd(8'h14, 32'h58);
    cmd(8'h20);
    rd(8'h14, 32'h50);
    $display("test status done");
    final_report();
  end
  initial begin
    #500000;
    err_count++;
    final_report();
  end
endmodule : uart_channel_command_tb
`default_nettype wire
